// [verilog/scdc_params.svh]
`ifndef SCDC_PARAMS_SVH
`define SCDC_PARAMS_SVH
`define SCDC_ADDR_STATUS     8'hc5
`define SCDC_ADDR_STATUS_EXT 8'hf7
`define SCDC_ADDR_CTRL       8'h10
`define SCDC_ADDR_FLAGS      8'h14
`define SCDC_CTRL_RESET      8'h80
`define SCDC_DIV_X4          2'b10
`define SCDC_DIV_X4_ALT      2'b01
`define SCDC_DIV_MULT        2'b00
`define SCDC_DIV_LOW         2'b11
`define SCDC_LOW_DIV         256
`define SCDC_MC_DIV          4
`define SCDC_STABLE_COUNT    65536
`define SCDC_BIT_DIV_HI      7
`define SCDC_BIT_DIV_LO      6
`define SCDC_BIT_SWB         5
`define SCDC_BIT_MENA        4
`define SCDC_BIT_MFAC        3
`define SCDC_BIT_RDY         3
`define SCDC_BIT_RING        2
`endif

// [verilog/scdc_pkg.sv]
`include "scdc_params.svh"
package scdc_pkg;
  typedef enum logic [1:0] {
    scdc_seq_idle  = 2'b00,
    scdc_seq_clear = 2'b01,
    scdc_seq_set   = 2'b11,
    scdc_seq_armed = 2'b10
  } scdc_seq_type;
  typedef struct packed {
    logic       read;
    logic       write;
    logic [7:0] address;
    logic [7:0] writedata;
  } scdc_bus_req_type;
  typedef struct packed {
    logic [2:0] serial_tx_busy;
    logic [2:0] serial_rx_busy;
  } scdc_serial_type;
endpackage

// [verilog/scdc_clock_divider.sv]
// Chosen here: register access over Avalon-MM.
`timescale 1ns/1ps
`include "scdc_params.svh"
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - system clock enable from oscillator direct, divided by 256, or multiplied
// - peripherals use system clock; machine cycle is system clock divided by 4
// - multiplier active only with enable set and divide select 00
// - factor select 0 gives times two, 1 gives times four
// - divide select 11 is low-speed: divide by 256, 1024 clocks per cycle
// - new clock setting takes effect on the second machine-cycle boundary after the write
// - divide select changes must pass through 10 or 01; others are rejected
// - multiplier engage needs clear enable, set factor, set enable, ready, 00
// - ready flag sets after 65536 source clocks once enable is set
// - writing 00 after ready engages multiplier on the second machine-cycle boundary after the write
// - leaving multiplier needs only a divide select write
// - switchback on acknowledged external interrupt in low-speed mode
// - disabled or masked external interrupts cause no switchback
// - switchback on enabled serial start bit or transmit buffer load
// - status bits 7,6,5 show powerfail, high and low levels in service
// - divisor writes ignored while any serial port is active
// - serial activity bits readable at c5h and f7h
// - divide select resets to 10
// - ring oscillator flag clears 65536 source clocks after stop exit
module scdc_clock_divider #(
  parameter int STABLE_COUNT = `SCDC_STABLE_COUNT
) (
  // clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rst_n,
  // avalon-mm slave
  input  wire scdc_pkg::scdc_bus_req_type avs_req,
  output logic [7:0]                     avs_readdata,
  output logic                           avs_waitrequest,
  // interrupt and serial status
  input  wire logic                      ext_irq_ack,
  input  wire logic                      powerfail_level_active,
  input  wire logic                      high_level_active,
  input  wire logic                      low_level_active,
  input  wire scdc_pkg::scdc_serial_type serial_busy,
  input  wire logic [2:0]                serial_start_bit,
  input  wire logic [2:0]                serial_tx_buffer_load,
  input  wire logic [2:0]                serial_port_enable,
  input  wire logic                      ring_exit,
  // generated clock enables
  output logic                           sys_clk_en,
  output logic                           mc_clk_en,
  output logic                           multiplier_active,
  output logic                           multiply_factor_select,
  output logic                           low_speed_mode
);
  import scdc_pkg::*;

  logic [1:0]   div_sel;
  logic [1:0]   pend_sel;
  logic         pend_valid;
  logic [1:0]   active_sel;
  logic         switchback_enable;
  logic         multiplier_enable;
  logic         multiplier_ready;
  logic         ring_osc_active;
  logic [16:0]  stable_cnt;
  logic [16:0]  ring_cnt;
  logic [7:0]   sys_cnt;
  logic [1:0]   mc_cnt;
  logic         rd_phase;
  scdc_seq_type seq;
  logic         wr_ctrl;
  logic         serial_active;
  logic         switchback;
  logic [1:0]   req_sel;
  logic         sel_ok;
  logic         mc_edge;
  logic         mult_en_q;

  ////////////////////////////////////////////////////////////////////////////////
  assign wr_ctrl       = avs_req.write && (avs_req.address == `SCDC_ADDR_CTRL);
  assign serial_active = |{serial_busy.serial_tx_busy, serial_busy.serial_rx_busy};
  assign req_sel       = {avs_req.writedata[`SCDC_BIT_DIV_HI], avs_req.writedata[`SCDC_BIT_DIV_LO]};
  // external irq acknowledge already implies enabled and not masked by a higher level
  assign switchback = switchback_enable && (active_sel == `SCDC_DIV_LOW) &&
                      (ext_irq_ack ||
                       |(serial_port_enable & (serial_start_bit | serial_tx_buffer_load)));

  always_comb begin
    sel_ok = 1'b0;
    if (req_sel == div_sel) begin
      sel_ok = 1'b1;
    end else if (req_sel == `SCDC_DIV_X4 || req_sel == `SCDC_DIV_X4_ALT) begin
      sel_ok = 1'b1;
    end else if (div_sel == `SCDC_DIV_X4 || div_sel == `SCDC_DIV_X4_ALT) begin
      if (req_sel == `SCDC_DIV_LOW) begin
        sel_ok = 1'b1;
      end else begin
        // the 00 write itself may be the first step after setting the enable
        sel_ok = (seq == scdc_seq_set || seq == scdc_seq_armed) && multiplier_ready &&
                 !ring_osc_active;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bus slave: single wait state on reads so readdata settles from a flop
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rd_phase <= 1'b0;
    end else begin
      rd_phase <= avs_req.read && !rd_phase;
    end
  end
  assign avs_waitrequest = avs_req.read && !rd_phase;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      avs_readdata <= 8'h00;
    end else if (avs_req.read && !rd_phase) begin
      case (avs_req.address)
        `SCDC_ADDR_STATUS: avs_readdata <= {powerfail_level_active, high_level_active,
                             low_level_active, 1'b0, serial_busy.serial_tx_busy[1:0],
                             serial_busy.serial_rx_busy[1:0]};
        `SCDC_ADDR_STATUS_EXT: avs_readdata <= {6'h00, serial_busy.serial_tx_busy[2],
                                 serial_busy.serial_rx_busy[2]};
        `SCDC_ADDR_CTRL: avs_readdata <= {div_sel, switchback_enable, multiplier_enable,
                           multiply_factor_select, 3'h0};
        `SCDC_ADDR_FLAGS: avs_readdata <= {4'h0, multiplier_ready, ring_osc_active, 2'h0};
        default: avs_readdata <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control register
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      switchback_enable      <= 1'b0;
      multiplier_enable      <= 1'b0;
      multiply_factor_select <= 1'b0;
    end else if (wr_ctrl) begin
      switchback_enable      <= avs_req.writedata[`SCDC_BIT_SWB];
      multiplier_enable      <= avs_req.writedata[`SCDC_BIT_MENA];
      multiply_factor_select <= avs_req.writedata[`SCDC_BIT_MFAC];
    end
  end

  // divide select; switchback outranks a software write in the same cycle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      div_sel <= `SCDC_DIV_X4;
    end else if (switchback) begin
      div_sel <= `SCDC_DIV_X4;
    end else if (wr_ctrl && !serial_active && sel_ok) begin
      div_sel <= req_sel;
    end
  end

  // engage sequence tracker; any write that clears the enable bit disarms it
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      seq <= scdc_seq_idle;
    end else if (wr_ctrl) begin
      case (seq)
        scdc_seq_idle:  seq <= !avs_req.writedata[`SCDC_BIT_MENA] ? scdc_seq_clear : scdc_seq_idle;
        scdc_seq_clear: seq <= avs_req.writedata[`SCDC_BIT_MENA] ? scdc_seq_set : scdc_seq_clear;
        scdc_seq_set:   seq <= avs_req.writedata[`SCDC_BIT_MENA] ? scdc_seq_armed : scdc_seq_clear;
        scdc_seq_armed: seq <= avs_req.writedata[`SCDC_BIT_MENA] ? scdc_seq_armed : scdc_seq_clear;
        default:        seq <= scdc_seq_idle;
      endcase
    end
  end

  // multiplier stabilisation counter
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      stable_cnt       <= 17'h00000;
      multiplier_ready <= 1'b0;
    end else if (!multiplier_enable) begin
      stable_cnt       <= 17'h00000;
      multiplier_ready <= 1'b0;
    end else if (stable_cnt == 17'(STABLE_COUNT - 1)) begin
      multiplier_ready <= 1'b1;
    end else begin
      stable_cnt <= stable_cnt + 17'h00001;
    end
  end

  // ring oscillator handover
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ring_osc_active <= 1'b0;
      ring_cnt        <= 17'h00000;
    end else if (ring_exit) begin
      ring_osc_active <= 1'b1;
      ring_cnt        <= 17'h00000;
    end else if (ring_osc_active) begin
      if (ring_cnt == 17'(STABLE_COUNT - 1)) begin
        ring_osc_active <= 1'b0;
      end else begin
        ring_cnt <= ring_cnt + 17'h00001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // clock generation; multiplied source modelled as enable every oscillator cycle
  assign mc_edge = sys_clk_en && (mc_cnt == 2'(`SCDC_MC_DIV - 1));

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sys_cnt <= 8'h00;
    end else if (active_sel == `SCDC_DIV_LOW) begin
      sys_cnt <= sys_cnt + 8'h01;
    end else begin
      sys_cnt <= 8'h00;
    end
  end

  always_comb begin
    case (active_sel)
      `SCDC_DIV_LOW: sys_clk_en = (sys_cnt == 8'(`SCDC_LOW_DIV - 1));
      default:       sys_clk_en = 1'b1;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mc_cnt <= 2'h0;
    end else if (sys_clk_en) begin
      mc_cnt <= mc_cnt + 2'h1;
    end
  end
  assign mc_clk_en = mc_edge;

  // pending setting applied on the machine-cycle boundary after the one that saw it
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      active_sel <= `SCDC_DIV_X4;
      pend_sel   <= `SCDC_DIV_X4;
      pend_valid <= 1'b0;
    end else if (mc_edge) begin
      pend_valid <= (div_sel != active_sel);
      pend_sel   <= div_sel;
      if (pend_valid) begin
        active_sel <= pend_sel;
      end
    end
  end

  // enable is sampled on the boundary so clearing it never cuts a machine cycle short
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mult_en_q <= 1'b0;
    end else if (mc_edge) begin
      mult_en_q <= multiplier_enable;
    end
  end

  assign multiplier_active = mult_en_q && (active_sel == `SCDC_DIV_MULT);
  assign low_speed_mode    = (active_sel == `SCDC_DIV_LOW);
endmodule

// [tb/scdc_clock_divider_properties.sv]
`timescale 1ns/1ps
module scdc_clock_divider_properties (
  // clock and reset
  input wire logic                       core_clk,
  input wire logic                       rst_n,
  // bus and generated enables
  input wire scdc_pkg::scdc_bus_req_type avs_req,
  input wire logic [7:0]                 avs_readdata,
  input wire logic                       avs_waitrequest,
  input wire logic                       sys_clk_en,
  input wire logic                       mc_clk_en,
  input wire logic                       multiplier_active,
  input wire logic                       low_speed_mode
);
  import scdc_pkg::*;
  logic [1:0] n_sys;
  logic [7:0] gap;
  logic       seen;
  logic       all_low;
  // reset leaves the machine-cycle phase open, so the first one is not judged
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      n_sys <= 2'h0;
      seen  <= 1'b0;
    end else if (mc_clk_en) begin
      n_sys <= 2'h0;
      seen  <= 1'b1;
    end else begin
      n_sys <= n_sys + 2'(sys_clk_en);
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      gap     <= 8'h0;
      all_low <= 1'b0;
    end else if (sys_clk_en) begin
      gap     <= 8'h0;
      all_low <= low_speed_mode;
    end else begin
      gap     <= gap + 8'h1;
      all_low <= all_low && low_speed_mode;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_answer;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  sequence s_taken_read;
    avs_req.read && !avs_waitrequest;
  endsequence
  AST_READ_WAIT: assert property ($rose(avs_req.read) |-> s_answer)
    else $error("read answer not one cycle late");
  AST_WRITE_NOWAIT: assert property (avs_req.write |-> !avs_waitrequest)
    else $error("write stalled");
  AST_UNMAPPED: assert property (s_taken_read ##0
    !(avs_req.address inside {8'hc5, 8'hf7, 8'h10, 8'h14}) |-> avs_readdata == 8'h00)
    else $error("unmapped read not zero");
  AST_MC_DIV4: assert property (mc_clk_en && seen |-> sys_clk_en && n_sys == 2'h3)
    else $error("machine cycle not four system clocks");
  AST_LOW_RATE: assert property (sys_clk_en && all_low && low_speed_mode |-> gap == 8'hff)
    else $error("low speed clock not one in 256");
  AST_FULL_RATE: assert property (!low_speed_mode [*2] |-> sys_clk_en)
    else $error("system clock missing outside low speed");
  AST_MULT_EDGE: assert property ($changed(multiplier_active) |-> $past(mc_clk_en))
    else $error("multiplier switched off a machine cycle boundary");
  AST_LOW_EDGE: assert property ($changed(low_speed_mode) |-> $past(mc_clk_en))
    else $error("low speed switched off a machine cycle boundary");
  AST_EXCL: assert property (!(multiplier_active && low_speed_mode))
    else $error("multiplier active in low speed");
endmodule
bind scdc_clock_divider scdc_clock_divider_properties u_props (
  .core_clk, .rst_n, .avs_req, .avs_readdata, .avs_waitrequest,
  .sys_clk_en, .mc_clk_en, .multiplier_active, .low_speed_mode);

// [tb/scdc_core_model.sv]
`timescale 1ns/1ps
module scdc_core_model (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // commands from the bench
  input  wire logic       irq_req,
  input  wire logic       irq_en,
  input  wire logic       hi_busy,
  input  wire logic       tx_go,
  // towards the divider
  output logic            ext_irq_ack,
  output logic [2:0]      tx_load,
  output logic            tx_busy
);
  logic [5:0] tx_left;
  // a disabled source or one masked by a higher level is never acknowledged
  always_ff @(posedge core_clk) ext_irq_ack <= irq_req && irq_en && !hi_busy;
  always_ff @(posedge core_clk) tx_load <= {2'h0, tx_go};
  // busy outlasts the load so that a divisor write lands inside it
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_left <= 6'h00;
    end else if (tx_go) begin
      tx_left <= 6'h08;
    end else begin
      tx_left <= tx_left - {5'h0, |tx_left};
    end
  end
  assign tx_busy = |tx_left;
endmodule

// [tb/test_system_clock_divider_control.sv]
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_errors++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, e); end end
module test_system_clock_divider_control;
  import scdc_pkg::*;
  logic             core_clk, rst_n, ring_exit, irq_req, irq_en, tx_go, tx_busy;
  logic             ext_irq_ack, pf, hi, lo, sys_clk_en, mc_clk_en, mult_on, factor, low;
  logic             avs_waitrequest;
  logic [7:0]       avs_readdata, q;
  logic [2:0]       tx_load;
  scdc_bus_req_type req;
  int               n_errors, check_count;
  scdc_clock_divider #(.STABLE_COUNT(16)) dut (
    .core_clk, .rst_n, .avs_req(req), .avs_readdata, .avs_waitrequest, .ext_irq_ack,
    .powerfail_level_active(pf), .high_level_active(hi), .low_level_active(lo),
    .serial_busy({2'h0, tx_busy, 3'h0}), .serial_start_bit(3'h0),
    .serial_tx_buffer_load(tx_load), .serial_port_enable(3'h7), .ring_exit,
    .sys_clk_en, .mc_clk_en, .multiplier_active(mult_on),
    .multiply_factor_select(factor), .low_speed_mode(low));
  scdc_core_model core (.core_clk, .rst_n, .irq_req, .irq_en, .hi_busy(hi), .tx_go,
    .ext_irq_ack, .tx_load, .tx_busy);
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic xfer(input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    req <= '{r, !r, a, d};
    do @(posedge core_clk); while (avs_waitrequest);
    q = avs_readdata;
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b1, a, 8'h00);
    `CHK(q, e)
  endtask
  task automatic pulse(input int k);
    @(posedge core_clk);
    if (k == 0) ring_exit <= 1'b1;
    else if (k == 1) irq_req <= 1'b1;
    else tx_go <= 1'b1;
    @(posedge core_clk);
    {ring_exit, irq_req, tx_go} <= 3'h0;
  endtask
  task automatic expect_lvl(ref logic s, input logic v, input int n);
    for (int i = 0; i < n && s !== v; i++) @(negedge core_clk);
    `CHK(s, v)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd(8'h10, 8'h80);
    rd(8'h14, 8'h00);
    rd(8'hc5, 8'ha0);
    xfer(1'b0, 8'hc5, 8'hff);
    rd(8'hf7, 8'h00);
    rd(8'h33, 8'h00);
    xfer(1'b0, 8'h10, 8'h00);
    rd(8'h10, 8'h80);
    xfer(1'b0, 8'h10, 8'h40);
    repeat (16) @(negedge core_clk);
    `CHK({low, mult_on}, 2'h0)
  endtask
  task automatic t_mult;
    logic [7:0] fb;
    xfer(1'b0, 8'h10, 8'h80);
    xfer(1'b0, 8'h10, 8'h98);
    repeat (24) @(negedge core_clk);
    pulse(0);
    xfer(1'b0, 8'h10, 8'h18);
    rd(8'h14, 8'h0c);
    rd(8'h10, 8'h98);
    for (int f = 0; f < 2; f++) begin
      fb = 8'(f << 3);
      xfer(1'b0, 8'h10, 8'h80 | fb);
      xfer(1'b0, 8'h10, 8'h90 | fb);
      q = 8'h00;
      for (int i = 0; i < 64 && q[3] !== 1'b1; i++) xfer(1'b1, 8'h14, 8'h00);
      `CHK(q, 8'h08)
      xfer(1'b0, 8'h10, 8'h10 | fb);
      expect_lvl(mult_on, 1'b1, 40);
      `CHK(factor, f[0])
      xfer(1'b0, 8'h10, 8'hd0 | fb);
      rd(8'h10, 8'h10 | fb);
      xfer(1'b0, 8'h10, 8'h80 | fb);
      expect_lvl(mult_on, 1'b0, 40);
    end
  endtask
  task automatic t_low;
    rd(8'hc5, 8'ha0);
    xfer(1'b0, 8'h10, 8'he0);
    expect_lvl(low, 1'b1, 40);
    xfer(1'b0, 8'h10, 8'h20);
    rd(8'h10, 8'he0);
    for (int c = 0; c < 3; c++) begin
      @(posedge core_clk);
      irq_en <= c > 0;
      hi     <= c == 1;
      pulse(1);
      // second machine-cycle boundary in low speed lies 2048 clocks out
      repeat (2100) @(negedge core_clk);
      `CHK(low, c != 2)
    end
    xfer(1'b0, 8'h10, 8'he0);
    expect_lvl(low, 1'b1, 40);
    pulse(2);
    expect_lvl(low, 1'b0, 2100);
    pulse(2);
    xfer(1'b0, 8'h10, 8'he0);
    rd(8'hc5, 8'ha4);
    rd(8'h10, 8'ha0);
    repeat (50) @(negedge core_clk);
    `CHK(low, 1'b0)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    {rst_n, ring_exit, irq_req, irq_en, tx_go, hi} = 6'h0;
    {pf, lo} = 2'h3;
    req = '0;
    n_errors = 0;
    check_count = 0;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    t_regs();
    t_mult();
    t_low();
    wrap_up();
  end
  initial begin
    #2000000;
    n_errors++;
    wrap_up();
  end
endmodule
